/* pkg/spc_pkg.sv */
package spc_pkg;
   // ==================================================
   // Register indices and byte addresses
   localparam logic [7:0] IDX_CTRL  = 8'h14;
   localparam logic [7:0] IDX_FLAGS = 8'h15;
   localparam logic [7:0] IDX_TXD   = 8'h16;
   localparam logic [7:0] IDX_RXD   = 8'h17;
   localparam logic [7:0] IDX_MASK  = 8'h18;
   localparam logic [9:0] ADDR_CTRL  = {IDX_CTRL, 2'b00};
   localparam logic [9:0] ADDR_FLAGS = {IDX_FLAGS, 2'b00};
   localparam logic [9:0] ADDR_TXD   = {IDX_TXD, 2'b00};
   localparam logic [9:0] ADDR_RXD   = {IDX_RXD, 2'b00};
   localparam logic [9:0] ADDR_MASK  = {IDX_MASK, 2'b00};
   // ==================================================
   // Control register fields
   localparam int CTL_IRQ_EN = 7;
   localparam int CTL_PE     = 6;
   localparam int CTL_RATE_HALF_DIVIDER_OFF   = 5;
   localparam int CTL_MASTER_SELECT   = 4;
   localparam int CTL_CLOCK_POLARITY   = 3;
   localparam int CTL_CLOCK_PHASE   = 2;
   localparam int CTL_RATE_SEL_HI   = 1;
   localparam int CTL_RATE_SEL_LO   = 0;
   // ==================================================
   // Flags and select register fields
   localparam int FLG_DONE = 7;
   localparam int FLG_WRITE_COLLISION_FLAG = 6;
   localparam int FLG_OVR  = 5;
   localparam int FLG_MODE_FAULT_FLAG = 4;
   localparam int FLG_SOD  = 2;
   localparam int FLG_SSM  = 1;
   localparam int FLG_SSI  = 0;
   // ==================================================
   // Reset values and bus answers
   localparam logic [7:0] CTRL_RST  = 8'h00;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [7:0] DATA_RST  = 8'h00;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // ==================================================
   // Serial clock half periods in core clocks
   localparam logic [5:0] HALF_DIV2  = 6'h01;
   localparam logic [5:0] HALF_DIV4  = 6'h02;
   localparam logic [5:0] HALF_DIV8  = 6'h04;
   localparam logic [5:0] HALF_DIV16 = 6'h08;
   localparam logic [5:0] HALF_DIV32 = 6'h10;
   localparam logic [5:0] HALF_DIV64 = 6'h20;
   localparam logic [3:0] LAST_EDGE  = 4'hf;
endpackage

/* pkg/spc_shift_if.sv */
`timescale 1ns/1ps
interface spc_shift_if;
   logic       enable;
   logic       master;
   logic       clock_polarity;
   logic       clock_phase;
   logic [5:0] half_cnt;
   logic       selected;
   logic       load;
   logic [7:0] load_data;
   logic       sck_in;
   logic       din;
   logic       sck_out;
   logic       dout;
   logic       active;
   logic       done;
   logic [7:0] rx_byte;
   modport ctl (output enable, master, clock_polarity, clock_phase, half_cnt, selected, load, load_data,
                sck_in, din, input sck_out, dout, active, done, rx_byte);
   modport eng (input enable, master, clock_polarity, clock_phase, half_cnt, selected, load, load_data,
                sck_in, din, output sck_out, dout, active, done, rx_byte);
endinterface

/* rtl/spc_shifter.sv */
`timescale 1ns/1ps
module spc_shifter (
   input wire logic aclk,
   input wire logic aresetn,
   spc_shift_if.eng sh
);
   import spc_pkg::*;
   logic [5:0] div_cnt;
   logic [3:0] edge_cnt;
   logic       running;
   logic       sck_lvl;
   logic       sck_prev;
   logic [7:0] tx_sr;
   logic [7:0] rx_sr;
   logic       tick;
   logic       slave_edge;
   logic       edge_ev;
   logic       sample_ev;
   logic       last_ev;
   logic       abort;

   assign abort      = !sh.enable || (!sh.master && !sh.selected);
   assign tick       = sh.master && running && (div_cnt == sh.half_cnt - 6'h01);
   assign slave_edge = !sh.master && sh.selected && (sh.sck_in != sck_prev);
   assign edge_ev    = tick || slave_edge;
   assign sample_ev  = edge_ev && (edge_cnt[0] == sh.clock_phase);
   assign last_ev    = edge_ev && (edge_cnt == LAST_EDGE);
   assign sh.sck_out = sh.clock_polarity ^ sck_lvl;
   assign sh.dout    = tx_sr[7];
   // Slave with phase 0 is busy from select, since the first edge is unknown
   assign sh.active  = sh.master ? running : (sh.clock_phase ? running : sh.selected);

   // ==================================================
   // Rate divider and edge sequencing
   always_ff @(posedge aclk) begin
      if (!aresetn || abort) begin
         div_cnt  <= 6'h00;
         edge_cnt <= 4'h0;
         running  <= 1'b0;
         sck_lvl  <= 1'b0;
      end else if (sh.master && sh.load && !running) begin
         div_cnt  <= 6'h00;
         edge_cnt <= 4'h0;
         running  <= 1'b1;
         sck_lvl  <= 1'b0;
      end else begin
         if (running && sh.master) begin
            div_cnt <= tick ? 6'h00 : div_cnt + 6'h01;
         end
         if (tick) begin
            sck_lvl <= !sck_lvl;
         end
         if (edge_ev) begin
            edge_cnt <= edge_cnt + 4'h1;
            running  <= !last_ev;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // Tracks the pin through reset, so an idle-high clock gives no false edge
         sck_prev <= sh.sck_in;
      end else begin
         sck_prev <= sh.sck_in;
      end
   end

   // ==================================================
   // Shift registers, msb first
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_sr <= DATA_RST;
         rx_sr <= DATA_RST;
      end else if (sh.load && !sh.active) begin
         tx_sr <= sh.load_data;
      end else if (sample_ev) begin
         rx_sr <= {rx_sr[6:0], sh.din};
      end else if (edge_ev && edge_cnt != 4'h0) begin
         tx_sr <= {tx_sr[6:0], 1'b0};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sh.done    <= 1'b0;
         sh.rx_byte <= DATA_RST;
      end else begin
         sh.done <= last_ev;
         if (last_ev) begin
            sh.rx_byte <= sample_ev ? {rx_sr[6:0], sh.din} : rx_sr;
         end
      end
   end
endmodule

/* rtl/spc_top.sv */
`timescale 1ns/1ps
module spc_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output wire logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output wire logic        s_axi_wready,
   output logic      [1:0]  s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output wire logic        s_axi_arready,
   output logic      [31:0] s_axi_rdata,
   output logic      [1:0]  s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        halt_mode,
   input  wire logic        sck_i,
   output wire logic        sck_o,
   output wire logic        sck_oe,
   input  wire logic        mosi_i,
   output wire logic        mosi_o,
   output wire logic        mosi_oe,
   input  wire logic        miso_i,
   output wire logic        miso_o,
   output wire logic        miso_oe,
   input  wire logic        ss_n_i,
   output wire logic        pins_to_port,
   output wire logic        irq,
   output wire logic        wake_req
);
   import spc_pkg::*;

   spc_shift_if sh ();

   logic [7:0]  ctrl_reg;
   logic        transfer_done_flag;
   logic        write_collision_flag;
   logic        overrun_flag;
   logic        mode_fault_flag;
   logic        output_disable;
   logic        select_source_mode;
   logic        internal_select_level;
   logic        irq_mask_bit;
   logic [7:0]  tx_data;
   logic [7:0]  rx_buf;
   logic        done_armed;
   logic        write_collision_flag_armed;
   logic        mode_fault_flag_armed;
   logic        aw_held;
   logic        w_held;
   logic [9:0]  aw_addr;
   logic [7:0]  w_data;
   logic        w_lane0;
   logic        wr_go;
   logic        rd_go;
   logic [9:0]  rd_addr;
   logic        wr_ctrl;
   logic        wr_flags;
   logic        wr_txd;
   logic        wr_mask;
   logic        rd_flags;
   logic        rd_rxd;
   logic        wr_hit;
   logic        rd_hit;
   logic        ss_low;
   logic        mode_fault_ev;
   logic        tx_accept;
   logic        collision;
   logic [7:0]  flags_view;
   logic [7:0]  rd_val;
   logic [7:0]  next_ctrl;
   logic [5:0]  next_half;
   logic        irq_enable;
   logic        port_enable;
   logic        master_select;

   assign irq_enable    = ctrl_reg[CTL_IRQ_EN];
   assign port_enable   = ctrl_reg[CTL_PE];
   assign master_select = ctrl_reg[CTL_MASTER_SELECT];

   // ==================================================
   // AXI4-Lite write channel
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign wr_go         = aw_held && w_held && !s_axi_bvalid;
   assign wr_hit        = (aw_addr == ADDR_CTRL) || (aw_addr == ADDR_FLAGS)
                       || (aw_addr == ADDR_TXD) || (aw_addr == ADDR_MASK);
   assign wr_ctrl       = wr_go && w_lane0 && (aw_addr == ADDR_CTRL);
   assign wr_flags      = wr_go && w_lane0 && (aw_addr == ADDR_FLAGS);
   assign wr_txd        = wr_go && w_lane0 && (aw_addr == ADDR_TXD);
   assign wr_mask       = wr_go && w_lane0 && (aw_addr == ADDR_MASK);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= 10'h000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= {s_axi_awaddr[9:2], 2'b00};
      end else if (wr_go) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held  <= 1'b0;
         w_data  <= DATA_RST;
         w_lane0 <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held  <= 1'b1;
         w_data  <= s_axi_wdata[7:0];
         w_lane0 <= s_axi_wstrb[0];
      end else if (wr_go) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ==================================================
   // AXI4-Lite read channel
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_go         = s_axi_arvalid && s_axi_arready;
   assign rd_addr       = {s_axi_araddr[9:2], 2'b00};
   assign rd_flags      = rd_go && (rd_addr == ADDR_FLAGS);
   assign rd_rxd        = rd_go && (rd_addr == ADDR_RXD);
   assign rd_hit        = (rd_addr == ADDR_CTRL) || (rd_addr == ADDR_FLAGS)
                       || (rd_addr == ADDR_RXD) || (rd_addr == ADDR_MASK)
                       || (rd_addr == ADDR_TXD);

   assign flags_view = {transfer_done_flag, write_collision_flag, overrun_flag,
                        mode_fault_flag, 1'b0, output_disable, select_source_mode,
                        internal_select_level};

   always_comb begin
      rd_val = 8'h00;
      unique case (rd_addr)
         ADDR_CTRL:  rd_val = ctrl_reg;
         ADDR_FLAGS: rd_val = flags_view;
         ADDR_RXD:   rd_val = rx_buf;
         ADDR_MASK:  rd_val = {7'h00, irq_mask_bit};
         default:    rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {24'h00_0000, rd_val};
         s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==================================================
   // Select, fault and control register
   assign ss_low        = select_source_mode ? !internal_select_level : !ss_n_i;
   assign mode_fault_ev = master_select && ss_low;

   always_comb begin
      next_ctrl = ctrl_reg;
      if (wr_ctrl) begin
         next_ctrl = w_data;
         if (mode_fault_flag && !mode_fault_flag_armed) begin
            next_ctrl[CTL_PE]   = ctrl_reg[CTL_PE];
            next_ctrl[CTL_MASTER_SELECT] = ctrl_reg[CTL_MASTER_SELECT];
         end
      end
      if (mode_fault_ev) begin
         next_ctrl[CTL_PE]   = 1'b0;
         next_ctrl[CTL_MASTER_SELECT] = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= CTRL_RST;
      end else begin
         ctrl_reg <= next_ctrl;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_fault_flag <= 1'b0;
         mode_fault_flag_armed      <= 1'b0;
      end else if (mode_fault_ev) begin
         mode_fault_flag <= 1'b1;
         mode_fault_flag_armed      <= 1'b0;
      end else if (wr_ctrl && mode_fault_flag_armed) begin
         mode_fault_flag <= 1'b0;
         mode_fault_flag_armed      <= 1'b0;
      end else if ((rd_flags || wr_flags) && mode_fault_flag) begin
         mode_fault_flag_armed <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         output_disable        <= 1'b0;
         select_source_mode    <= 1'b0;
         internal_select_level <= 1'b0;
         irq_mask_bit          <= 1'b0;
      end else begin
         if (wr_flags) begin
            output_disable        <= w_data[FLG_SOD];
            select_source_mode    <= w_data[FLG_SSM];
            internal_select_level <= w_data[FLG_SSI];
         end
         if (wr_mask) begin
            irq_mask_bit <= w_data[0];
         end
      end
   end

   // ==================================================
   // Transmit data and write collision
   assign collision = wr_txd && sh.active;
   assign tx_accept = wr_txd && !sh.active && (!transfer_done_flag || done_armed);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_data <= DATA_RST;
      end else if (tx_accept) begin
         tx_data <= w_data;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         write_collision_flag <= 1'b0;
         write_collision_flag_armed           <= 1'b0;
      end else if (collision) begin
         write_collision_flag <= 1'b1;
         write_collision_flag_armed           <= 1'b0;
      end else if (rd_rxd && write_collision_flag_armed) begin
         write_collision_flag <= 1'b0;
         write_collision_flag_armed           <= 1'b0;
      end else if (rd_flags && write_collision_flag) begin
         write_collision_flag_armed <= 1'b1;
      end
   end

   // ==================================================
   // Transfer done, receive buffer and overrun
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         transfer_done_flag <= 1'b0;
         done_armed         <= 1'b0;
      end else if (sh.done) begin
         transfer_done_flag <= 1'b1;
         done_armed         <= 1'b0;
      end else if ((rd_rxd || tx_accept) && done_armed) begin
         transfer_done_flag <= 1'b0;
         done_armed         <= 1'b0;
      end else if ((rd_flags || wr_flags) && transfer_done_flag) begin
         done_armed <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_buf       <= DATA_RST;
         overrun_flag <= 1'b0;
      end else if (sh.done && transfer_done_flag) begin
         overrun_flag <= 1'b1;
      end else if (sh.done) begin
         rx_buf <= sh.rx_byte;
      end else if ((rd_rxd || tx_accept) && done_armed) begin
         overrun_flag <= 1'b0;
      end
   end

   // ==================================================
   // Rate select and shift engine
   always_comb begin
      unique case ({ctrl_reg[CTL_RATE_HALF_DIVIDER_OFF], ctrl_reg[CTL_RATE_SEL_HI], ctrl_reg[CTL_RATE_SEL_LO]})
         3'b100:  next_half = HALF_DIV2;
         3'b000:  next_half = HALF_DIV4;
         3'b001:  next_half = HALF_DIV8;
         3'b110:  next_half = HALF_DIV16;
         3'b010:  next_half = HALF_DIV32;
         default: next_half = HALF_DIV64;
      endcase
   end

   assign sh.enable    = port_enable;
   assign sh.master    = master_select;
   assign sh.clock_polarity      = ctrl_reg[CTL_CLOCK_POLARITY];
   assign sh.clock_phase      = ctrl_reg[CTL_CLOCK_PHASE];
   assign sh.half_cnt  = next_half;
   assign sh.selected  = ss_low;
   assign sh.load      = tx_accept;
   assign sh.load_data = w_data;
   assign sh.sck_in    = sck_i;
   assign sh.din       = master_select ? miso_i : mosi_i;

   spc_shifter u_shifter (
      .aclk    (aclk),
      .aresetn (aresetn),
      .sh      (sh)
   );

   // ==================================================
   // Pins, interrupt and wake
   assign pins_to_port = port_enable;
   assign sck_o        = sh.sck_out;
   assign sck_oe       = port_enable && master_select;
   assign mosi_o       = sh.dout;
   assign mosi_oe      = port_enable && master_select && !output_disable;
   assign miso_o       = sh.dout;
   assign miso_oe      = port_enable && !master_select && ss_low && !output_disable;
   assign irq          = irq_enable && irq_mask_bit
                      && (transfer_done_flag || mode_fault_flag);
   assign wake_req     = irq && !halt_mode;

   // ==================================================
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_collision_drop: assert property (collision |=> write_collision_flag && $stable(tx_data))
      else $error("collision write changed transmit data");
   chk_write_collision_flag_no_irq: assert property ($rose(write_collision_flag) && !transfer_done_flag
      && !mode_fault_flag |-> !irq) else $error("collision raised interrupt");
   chk_fault_sets: assert property (mode_fault_ev |=> mode_fault_flag && !port_enable
      && !master_select) else $error("fault did not set flag and drop mode");
   chk_fault_locks: assert property (mode_fault_flag && !mode_fault_flag_armed && !mode_fault_ev
      && wr_ctrl |=> !port_enable) else $error("port enable set during fault");
   chk_slave_nofault: assert property (!master_select && !mode_fault_flag |=> !mode_fault_flag)
      else $error("fault set in slave mode");
   chk_rxbuf_keep: assert property (sh.done && transfer_done_flag |=> $stable(rx_buf))
      else $error("receive buffer overwritten");
   chk_irq_gate: assert property (irq |-> irq_enable && irq_mask_bit)
      else $error("interrupt without enable and mask");
   chk_done_flag: assert property (sh.done |=> transfer_done_flag [*1] ##0 !sh.done)
      else $error("done flag not set after byte");
   chk_halt_wake: assert property (halt_mode |-> !wake_req)
      else $error("wake raised in halt");
endmodule

/* tb/spc_peer.sv */
`timescale 1ns/1ps
// ==================================================
// Far-side slave, clock mode 0, one byte per eight clocks
module spc_peer (
   input  wire logic       sck,
   input  wire logic       mosi,
   output wire logic       miso,
   input  wire logic [7:0] reply,
   output logic      [7:0] got
);
   logic [2:0] cnt = 3'h0;
   logic [2:0] idx = 3'h0;
   assign miso = reply[3'h7 - idx];
   always @(posedge sck) begin
      got <= {got[6:0], mosi};
      cnt <= cnt + 3'h1;
   end
   // Next bit goes out on the trailing edge
   always @(negedge sck) begin
      idx <= cnt;
   end
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
   import spc_pkg::*;
   logic        aclk, aresetn, awv, wv, arv, ss_n, halt;
   logic [31:0] awa, wd, ara, rdata;
   logic [1:0]  bresp, rresp;
   logic        awr, wr_rdy, bv, arr, rv, sck_o, sck_oe, mosi_o, mosi_oe;
   logic        miso_o, miso_oe, miso, pins, irq, wake, s_sck, s_mosi;
   logic [7:0]  tx, reply, got, sg;
   logic [33:0] q[$];
   logic [1:0]  bq[$];
   int          mismatches = 0, num_checks = 0, seed = 8396, edges = 0;
   time         t_rise, hw;
   logic [7:0]  rc [5] = '{8'h00, 8'h01, 8'h22, 8'h02, 8'h03};
   int          hv [5] = '{2, 4, 8, 16, 32};
   spc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(1'b1), .halt_mode(halt),
      .sck_i(s_sck), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(s_mosi), .mosi_o(mosi_o),
      .mosi_oe(mosi_oe), .miso_i(miso), .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_n),
      .pins_to_port(pins), .irq(irq), .wake_req(wake));
   spc_peer peer (.sck(sck_oe ? sck_o : 1'b0), .mosi(mosi_oe ? mosi_o : ~got[0]),
      .miso(miso), .reply(reply), .got(got));
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   always @(posedge sck_o) begin
      t_rise = $time;
      edges++;
   end
   always @(negedge sck_o) hw = $time - t_rise;
   // ==================================================
   // Checking and bus tasks
   task tally_and_finish;
      if (mismatches == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task fail(input string m);
      mismatches++;
      $display("CHECK FAILED %0t %s", $time, m);
   endtask
   task chk(input logic ok, input string m);
      num_checks++;
      if (ok !== 1'b1) fail(m);
   endtask
   task tmo(input int n);
      if (n >= 3000) begin
         fail("timeout");
         tally_and_finish();
      end
   endtask
   always @(posedge aclk) begin
      if (aresetn === 1'b1 && rv === 1'b1 && q.size() > 0) begin
         num_checks++;
         if ({rresp, rdata} !== q[0]) fail("read value");
         void'(q.pop_front());
      end
      if (aresetn === 1'b1 && bv === 1'b1 && bq.size() > 0) begin
         num_checks++;
         if (bresp !== bq[0]) fail("write response");
         void'(bq.pop_front());
      end
   end
   task wr(input logic [9:0] a, input logic [7:0] d);
      wrr(a, d, RESP_OKAY);
   endtask
   task wrr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      awa <= {22'h0, a};
      wd <= {24'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      bq.push_back(r);
      do begin
         @(posedge aclk);
         if (awr === 1'b1) awv <= 1'b0;
         if (wr_rdy === 1'b1) wv <= 1'b0;
      end while ((awv || wv) && ++n < 3000);
      do @(posedge aclk); while (bv !== 1'b1 && ++n < 3000);
      tmo(n);
   endtask
   task rd(input logic [9:0] a, input logic [7:0] d, input logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      ara <= {22'h0, a};
      arv <= 1'b1;
      q.push_back({r, 24'h0, d});
      do @(posedge aclk); while (arr !== 1'b1 && ++n < 3000);
      arv <= 1'b0;
      do @(posedge aclk); while (rv !== 1'b1 && ++n < 3000);
      tmo(n);
   endtask
   // ==================================================
   // Main sequence
   initial begin
      int i, n;
      aresetn = 1'b0; awv = 1'b0; wv = 1'b0; arv = 1'b0; ss_n = 1'b1; halt = 1'b0;
      awa = 32'h0; wd = 32'h0; ara = 32'h0; reply = 8'h00; s_sck = 1'b0; s_mosi = 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(ADDR_CTRL, 8'h00, RESP_OKAY);
      rd(ADDR_FLAGS, 8'h00, RESP_OKAY);
      rd(10'h3fc, 8'h00, RESP_SLVERR);
      wrr(10'h3fc, 8'hff, RESP_SLVERR);
      chk(pins === 1'b0 && sck_oe === 1'b0, "reset pins");
      wr(ADDR_MASK, 8'h01);
      for (i = 0; i < 5; i++) begin
         wr(ADDR_CTRL, 8'hd0 | rc[i]);
         chk(pins === 1'b1 && sck_oe === 1'b1 && sck_o === 1'b0, "master pins");
         tx = 8'($random(seed));
         reply <= 8'($random(seed));
         edges = 0;
         wr(ADDR_TXD, tx);
         if (i == 0) wr(ADDR_TXD, ~tx);
         n = 0;
         do @(posedge aclk); while (irq !== 1'b1 && ++n < 3000);
         tmo(n);
         chk(edges == 8 && hw == 20 * hv[i] && got === tx, "frame");
         rd(ADDR_FLAGS, (i == 0) ? 8'hc0 : 8'h80, RESP_OKAY);
         rd(ADDR_RXD, reply, RESP_OKAY);
         chk(irq === 1'b0, "irq clear");
      end
      wr(ADDR_MASK, 8'h00);
      ss_n <= 1'b0;
      n = 0;
      do @(posedge aclk); while (pins !== 1'b0 && ++n < 3000);
      tmo(n);
      ss_n <= 1'b1;
      chk(irq === 1'b0 && sck_oe === 1'b0, "fault masked");
      rd(ADDR_CTRL, 8'h83, RESP_OKAY);
      wr(ADDR_CTRL, 8'hd3);
      rd(ADDR_CTRL, 8'h83, RESP_OKAY);
      wr(ADDR_MASK, 8'h01);
      chk(irq === 1'b1 && wake === 1'b1, "fault irq");
      halt <= 1'b1;
      repeat (2) @(posedge aclk);
      chk(wake === 1'b0, "halt wake");
      halt <= 1'b0;
      rd(ADDR_FLAGS, 8'h10, RESP_OKAY);
      wr(ADDR_CTRL, 8'h80);
      rd(ADDR_FLAGS, 8'h00, RESP_OKAY);
      chk(irq === 1'b0, "fault cleared");
      // ==================================================
      // Slave frames, clock idle high, second byte overruns
      s_sck <= 1'b1;
      wr(ADDR_CTRL, 8'hc8);
      tx = 8'($random(seed));
      reply <= 8'($random(seed));
      wr(ADDR_TXD, tx);
      ss_n <= 1'b0;
      wr(ADDR_TXD, ~tx);
      chk(miso_oe === 1'b1 && sck_oe === 1'b0 && sck_o === 1'b1, "slave pins");
      for (i = 0; i < 16; i++) begin
         s_mosi <= reply[7 - (i % 8)];
         repeat (2) @(posedge aclk);
         s_sck <= 1'b0;
         repeat (2) @(posedge aclk);
         if (i < 8) sg = {sg[6:0], miso_o};
         s_sck <= 1'b1;
         repeat (2) @(posedge aclk);
      end
      ss_n <= 1'b1;
      chk(sg === tx && irq === 1'b1, "slave frame");
      rd(ADDR_FLAGS, 8'he0, RESP_OKAY);
      rd(ADDR_RXD, reply, RESP_OKAY);
      rd(ADDR_FLAGS, 8'h00, RESP_OKAY);
      chk(irq === 1'b0, "slave clear");
      tally_and_finish();
   end
endmodule
